/* File: design/utg_consts.svh */
// constants of the transmit gate and half-duplex control block
// assumes inclusion by bare name from the design files
`ifndef UTG_CONSTS_SVH
`define UTG_CONSTS_SVH

// register byte addresses
`define UTG_TPR_OFFS   32'h4000_8030
`define UTG_STAT_OFFS  32'h4000_8034
`define UTG_HDC_OFFS   32'h4000_8040

// field positions
`define UTG_TP_BIT     7
`define UTG_HD_BIT     0
`define UTG_ST_BUSY    0
`define UTG_ST_STALL   1
`define UTG_ST_LOCK    2

// reset values
`define UTG_TP_RST     1'h1
`define UTG_HD_RST     1'h0

// bus answers
`define UTG_RESP_OKAY  2'h0
`define UTG_RESP_SLV   2'h2

`endif

/* File: design/utg_pkg.sv */
// types of the transmit gate and half-duplex control block
// assumes the constants header is included by the design files
package utg_pkg;

    // axi4-lite requests from the master
    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } utg_axil_req_t;

    // axi4-lite answers to the master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } utg_axil_rsp_t;

    // transmit gate states, one-hot
    typedef enum logic [1:0] {
        UTG_IDLE = 2'b01,
        UTG_SEND = 2'b10
    } utg_tx_state_t;

endpackage : utg_pkg

/* File: design/utg_rx_lock.sv */
// receiver lock of the half-duplex mode
// assumes rx_active_i comes from the receiver on the same clock
`timescale 1ns/1ps
module utg_rx_lock import utg_pkg::*; (
    input  wire logic clk_i,       // port clock
    input  wire logic arst_n_i,    // async reset, low
    input  wire logic hd_en_i,     // half-duplex enable
    input  wire logic rx_active_i, // character being received
    output logic      rx_lock_o    // receiver locked
);

    logic lock;      // lock state
    logic next_lock; // next lock state

    // lock when idle or once the running character ends
    always_comb begin
        next_lock = hd_en_i & (lock | ~rx_active_i);
        if (!hd_en_i) begin
            next_lock = 1'b0;
        end
    end

    // register the lock
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock <= 1'b0;
        end else begin
            lock <= next_lock;
        end
    end

    assign rx_lock_o = lock;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    full_duplex_a: assert property (!hd_en_i |=> !rx_lock_o)
        else $error("receiver locked outside half duplex");
    lock_idle_a: assert property (hd_en_i && !rx_active_i |=> rx_lock_o)
        else $error("idle receiver not locked");
    lock_wait_a: assert property (hd_en_i && rx_active_i && !rx_lock_o |=> !rx_lock_o)
        else $error("receiver locked mid character");
    cov_lock: cover property (hd_en_i && rx_active_i ##1 !rx_active_i ##1 rx_lock_o);

endmodule : utg_rx_lock

/* File: design/utg_top.sv */
// transmit gate and half-duplex control of a serial port
// assumes holding register, shifter and receiver sit on clk_i;
// software reaches the registers over axi4-lite
`timescale 1ns/1ps
`include "utg_consts.svh"
module utg_top import utg_pkg::*; #(
    parameter int DATA_W = 8 // character width
) (
    input  wire logic              clk_i,        // port clock, 25 MHz
    input  wire logic              arst_n_i,     // async reset, low
    input  wire utg_axil_req_t     axi_i,        // bus requests
    output utg_axil_rsp_t          axi_o,        // bus answers
    input  wire logic              hold_valid_i, // character queued
    input  wire logic [DATA_W-1:0] hold_data_i,  // queued character
    output logic                   hold_ready_o, // character taken
    output logic                   shift_load_o, // load pulse to shifter
    output logic [DATA_W-1:0]      shift_data_o, // character to shifter
    input  wire logic              shift_done_i, // shifter finished char
    input  wire logic              rx_active_i,  // reception running
    output logic                   hd_en_o,      // half-duplex mode
    output logic                   rx_lock_o     // receiver locked
);

    // refuse widths the shifter cannot take
    if (DATA_W < 5 || DATA_W > 9) begin : g_bad_width
        $error("DATA_W must lie between 5 and 9");
    end

    // ---- write channel state ----
    logic        aw_full;       // write address held
    logic        next_aw_full;
    logic [31:0] aw_addr;       // held write address
    logic [31:0] next_aw_addr;
    logic        w_full;        // write data held
    logic        next_w_full;
    logic [31:0] w_data;        // held write data
    logic [31:0] next_w_data;
    logic [3:0]  w_strb;        // held byte strobes
    logic [3:0]  next_w_strb;
    logic        bvalid;        // write answer pending
    logic        next_bvalid;
    logic [1:0]  bresp;         // write answer code
    logic [1:0]  next_bresp;
    logic        wr_fire;       // write performed now
    logic        wr_hit;        // write address mapped

    // ---- read channel state ----
    logic        rvalid;        // read answer pending
    logic        next_rvalid;
    logic [31:0] rdata;         // read answer data
    logic [31:0] next_rdata;
    logic [1:0]  rresp;         // read answer code
    logic [1:0]  next_rresp;
    logic        rd_fire;       // read address taken

    // ---- control registers ----
    logic        permit;        // transmit permit
    logic        next_permit;
    logic        hd_en;         // half-duplex enable
    logic        next_hd_en;

    // ---- transmit gate ----
    utg_tx_state_t     st;      // gate state
    utg_tx_state_t     next_st;
    logic              load;    // load pulse
    logic              next_load;
    logic [DATA_W-1:0] sdata;   // character for shifter
    logic [DATA_W-1:0] next_sdata;
    logic              pop;     // holding register may give

    // write decode against held address
    assign wr_hit = (aw_addr == `UTG_TPR_OFFS) || (aw_addr == `UTG_HDC_OFFS);
    // both halves present and no answer outstanding
    assign wr_fire = aw_full && w_full && !bvalid;

    // write channel next values
    always_comb begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full  = w_full;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        // take address when free
        if (axi_i.awvalid && !aw_full) begin
            next_aw_full = 1'b1;
            next_aw_addr = axi_i.awaddr;
        end
        // take data when free, in either order
        if (axi_i.wvalid && !w_full) begin
            next_w_full = 1'b1;
            next_w_data = axi_i.wdata;
            next_w_strb = axi_i.wstrb;
        end
        // answer consumed
        if (bvalid && axi_i.bready) begin
            next_bvalid = 1'b0;
        end
        // perform write and raise answer
        if (wr_fire) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_hit ? `UTG_RESP_OKAY : `UTG_RESP_SLV;
        end
    end

    // write channel registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_full <= 1'b0;
            aw_addr <= 32'h0;
            w_full  <= 1'b0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= 2'h0;
        end else begin
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full  <= next_w_full;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
        end
    end

    // read address accepted while no answer waits
    assign rd_fire = axi_i.arvalid && !rvalid;

    // read channel next values
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        // answer consumed
        if (rvalid && axi_i.rready) begin
            next_rvalid = 1'b0;
        end
        // decode and capture, reserved bits read zero
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rdata  = 32'h0;
            next_rresp  = `UTG_RESP_OKAY;
            case (axi_i.araddr)
                `UTG_TPR_OFFS: begin
                    next_rdata[`UTG_TP_BIT] = permit;
                end
                `UTG_HDC_OFFS: begin
                    next_rdata[`UTG_HD_BIT] = hd_en;
                end
                `UTG_STAT_OFFS: begin
                    next_rdata[`UTG_ST_BUSY]  = (st == UTG_SEND);
                    next_rdata[`UTG_ST_STALL] = !permit && hold_valid_i;
                    next_rdata[`UTG_ST_LOCK]  = rx_lock_o;
                end
                default: begin
                    next_rresp = `UTG_RESP_SLV;
                end
            endcase
        end
    end

    // read channel registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= 2'h0;
        end else begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    // bus answers
    always_comb begin
        axi_o.awready = !aw_full;
        axi_o.wready  = !w_full;
        axi_o.bvalid  = bvalid;
        axi_o.bresp   = bresp;
        axi_o.arready = !rvalid;
        axi_o.rvalid  = rvalid;
        axi_o.rdata   = rdata;
        axi_o.rresp   = rresp;
    end

    // control register next values, only low byte lane matters
    always_comb begin
        next_permit = permit;
        next_hd_en  = hd_en;
        if (wr_fire && w_strb[0]) begin
            // permit write
            if (aw_addr == `UTG_TPR_OFFS) begin
                next_permit = w_data[`UTG_TP_BIT];
            end
            // half-duplex write
            if (aw_addr == `UTG_HDC_OFFS) begin
                next_hd_en = w_data[`UTG_HD_BIT];
            end
        end
    end

    // control registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            permit <= `UTG_TP_RST;
            hd_en  <= `UTG_HD_RST;
        end else begin
            permit <= next_permit;
            hd_en  <= next_hd_en;
        end
    end

    // the holding register gives only while idle and permitted
    assign pop          = (st == UTG_IDLE) && permit;
    assign hold_ready_o = pop;

    // transmit gate next values
    always_comb begin
        next_st    = st;
        next_load  = 1'b0;
        next_sdata = sdata;
        case (st)
            UTG_IDLE: begin
                // move one character once earlier ones are out
                if (hold_valid_i && pop) begin
                    next_load  = 1'b1;
                    next_sdata = hold_data_i;
                    next_st    = UTG_SEND;
                end
            end
            UTG_SEND: begin
                // finish character even if permit drops
                if (shift_done_i) begin
                    next_st = UTG_IDLE;
                end
            end
            default: begin
                next_st = UTG_IDLE;
            end
        endcase
    end

    // transmit gate registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st    <= UTG_IDLE;
            load  <= 1'b0;
            sdata <= '0;
        end else begin
            st    <= next_st;
            load  <= next_load;
            sdata <= next_sdata;
        end
    end

    assign shift_load_o = load;
    assign shift_data_o = sdata;
    assign hd_en_o      = hd_en;

    // receiver lock of half-duplex mode
    utg_rx_lock u_rx_lock (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .hd_en_i     (hd_en),
        .rx_active_i (rx_active_i),
        .rx_lock_o   (rx_lock_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // blocked loads
    no_blocked_load_a: assert property (shift_load_o |-> $past(permit))
        else $error("character loaded without permit");
    // prompt load when permitted
    load_prompt_a: assert property (st == UTG_IDLE && permit && hold_valid_i |=> shift_load_o)
        else $error("permitted character not loaded");
    // running character completes
    send_finish_a: assert property (st == UTG_SEND && !shift_done_i |=> st == UTG_SEND && !shift_load_o)
        else $error("character cut short");
    // no further load after permit drops
    stop_after_a: assert property (!permit && st == UTG_SEND ##1 !permit |-> !shift_load_o [*2])
        else $error("load after permit cleared");
    // exact character forwarded
    data_kept_a: assert property (shift_load_o |-> shift_data_o == $past(hold_data_i))
        else $error("forwarded character differs");
    // single load per character
    single_load_a: assert property (shift_load_o |=> !shift_load_o && st == UTG_SEND)
        else $error("character loaded twice");
    // resume on permit set
    resume_a: assert property ($rose(permit) && st == UTG_IDLE && hold_valid_i |=> shift_load_o)
        else $error("no resume after permit set");
    // write reaches permit register
    permit_write_a: assert property (wr_fire && w_strb[0] && aw_addr == `UTG_TPR_OFFS
                                     |=> permit == $past(w_data[`UTG_TP_BIT]))
        else $error("permit write lost");
    // write answer timing
    write_answer_a: assert property (wr_fire |=> bvalid)
        else $error("write answer missing");

    cov_send: cover property (shift_load_o ##[1:50] shift_done_i);
    cov_stall: cover property (!permit && hold_valid_i ##[1:50] shift_load_o);
    cov_cut: cover property (st == UTG_SEND && $fell(permit));

endmodule : utg_top

/* File: testbench/uart_tx_gate_half_duplex_tb.sv */
// self-checking bench of the transmit gate and half-duplex control
// assumes the station model stands for shifter and receiver
`timescale 1ns/1ps
`include "utg_consts.svh"
module uart_tx_gate_half_duplex_tb import utg_pkg::*; ;
    logic          clk_i = 1'b0;   // 25 MHz port clock
    logic          arst_n_i = 1'b0; // reset, low
    utg_axil_req_t req = '0;       // bus master signals
    utg_axil_rsp_t rsp;            // bus slave answers
    logic          hv = 1'b0;      // character queued
    logic [7:0]    hd = 8'h00;     // queued character
    logic [7:0]    dly = 8'h02;    // station character time
    logic [7:0]    rxlen = 8'h00;  // station reception time
    logic          rxgo = 1'b0;    // start reception
    logic [3:0]    wst = 4'hf;     // byte strobes of the next write
    logic          hrdy, load, done, rxa, half_duplex_ctrl, lock;
    logic [7:0]    sdat;           // character to shifter
    logic          take = 1'b0;    // pop seen this cycle
    logic [7:0]    tq[$];          // characters still to offer
    logic [7:0]    eq[$];          // characters expected at the shifter
    int            fails = 0;
    int            checks = 0;
    int            loads = 0;
    int            seed = 94;
    int            l0;

    utg_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .axi_i(req), .axi_o(rsp),
        .hold_valid_i(hv), .hold_data_i(hd), .hold_ready_o(hrdy), .shift_load_o(load),
        .shift_data_o(sdat), .shift_done_i(done), .rx_active_i(rxa), .hd_en_o(half_duplex_ctrl),
        .rx_lock_o(lock));

    utg_station stn_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .load_i(load), .dly_i(dly),
        .rx_go_i(rxgo), .rx_len_i(rxlen), .done_o(done), .rx_active_o(rxa));

    // clock
    always #20 clk_i = ~clk_i;

    // compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // bus write; entered just after a rising edge
    task automatic wchk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, b;
        logic [1:0] r;
        b = 1'b0;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= wst;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!b) begin
            @(negedge clk_i);
            b = rsp.bvalid;
            r = rsp.bresp;
            ah = req.awvalid & rsp.awready;
            wh = req.wvalid & rsp.wready;
            @(posedge clk_i);
            if (ah) req.awvalid <= 1'b0;
            if (wh) req.wvalid <= 1'b0;
        end
        // every call drives bready high again, and nothing lowers it between writes
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wchk

    // bus read and compare; entered just after a rising edge
    task automatic rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ah, dn;
        logic [31:0] d;
        logic [1:0] r;
        dn = 1'b0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        while (!dn) begin
            @(negedge clk_i);
            dn = rsp.rvalid;
            d = rsp.rdata;
            r = rsp.rresp;
            ah = req.arvalid & rsp.arready;
            @(posedge clk_i);
            if (ah) req.arvalid <= 1'b0;
        end
        // every call drives rready high again, and nothing lowers it between reads
        chk("rdata", e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rchk

    // queue random characters
    task automatic send(input int n);
        logic [7:0] c;
        repeat (n) begin
            c = 8'($random(seed));
            tq.push_back(c);
            eq.push_back(c);
        end
    endtask : send

    // wait until every character went out, with random character times
    task automatic drain;
        while (eq.size() != 0) begin
            @(posedge clk_i);
            dly <= 8'h01 + 8'($random(seed) & 15);
        end
        repeat (40) @(posedge clk_i);
    endtask : drain

    // monitor shifter loads where outputs are settled
    always @(negedge clk_i) begin
        take = hv & hrdy;
        if (load === 1'b1) begin
            loads++;
            chk("shift_data_o", {24'h0, (eq.size() != 0) ? eq.pop_front() : ~sdat}, {24'h0, sdat});
        end
    end

    // holding register driver; released data shows the inverse
    always @(posedge clk_i) begin
        if (take) void'(tq.pop_front());
        hv <= (tq.size() != 0);
        hd <= (tq.size() != 0) ? tq[0] : ~hd;
    end

    // verdict
    task automatic report_and_stop;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // watchdog, far beyond the about 400 cycles the tests need
    initial begin
        #(40 * 5000);
        fails++;
        report_and_stop;
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(negedge clk_i);
        chk("hold_ready_o", 32'h1, {31'h0, hrdy});
        chk("hd_en_o", 32'h0, {31'h0, half_duplex_ctrl});
        @(posedge clk_i);
        rchk(`UTG_TPR_OFFS, 32'h0000_0080, `UTG_RESP_OKAY);
        rchk(`UTG_HDC_OFFS, 32'h0, `UTG_RESP_OKAY);
        rchk(32'h4000_8038, 32'h0, `UTG_RESP_SLV);
        $display("test reset done");
        // random stream with permit set
        send(12);
        drain;
        chk("loads", 32'd12, loads);
        $display("test stream done");
        // permit cleared mid-character, then restored
        dly <= 8'd30;
        l0 = loads;
        send(4);
        while (loads == l0) @(posedge clk_i);
        wchk(`UTG_TPR_OFFS, 32'h0, `UTG_RESP_OKAY);
        repeat (60) @(posedge clk_i);
        chk("loads", l0 + 1, loads);
        rchk(`UTG_STAT_OFFS, 32'h2, `UTG_RESP_OKAY);
        wchk(`UTG_TPR_OFFS, 32'h80, `UTG_RESP_OKAY);
        drain;
        chk("loads", l0 + 4, loads);
        $display("test permit done");
        // reception in full duplex, then half duplex set during it
        rxlen <= 8'd24;
        rxgo <= 1'b1;
        @(posedge clk_i);
        rxgo <= 1'b0;
        @(negedge clk_i);
        chk("rx_lock_o", 32'h0, {31'h0, lock});
        @(posedge clk_i);
        wchk(`UTG_HDC_OFFS, 32'h1, `UTG_RESP_OKAY);
        @(negedge clk_i);
        chk("rx_lock_o", 32'h0, {31'h0, lock});
        while (rxa) @(negedge clk_i);
        repeat (2) @(negedge clk_i);
        chk("rx_lock_o", 32'h1, {31'h0, lock});
        @(posedge clk_i);
        rchk(`UTG_STAT_OFFS, 32'h4, `UTG_RESP_OKAY);
        wchk(`UTG_HDC_OFFS, 32'h0, `UTG_RESP_OKAY);
        repeat (2) @(negedge clk_i);
        chk("rx_lock_o", 32'h0, {31'h0, lock});
        @(posedge clk_i);
        wchk(`UTG_HDC_OFFS, 32'h1, `UTG_RESP_OKAY);
        repeat (2) @(negedge clk_i);
        chk("rx_lock_o", 32'h1, {31'h0, lock});
        chk("hd_en_o", 32'h1, {31'h0, half_duplex_ctrl});
        $display("test half duplex done");
        // unmapped and read-only places refuse writes; a write without lane 0 is ignored
        @(posedge clk_i);
        wchk(32'h4000_803c, 32'h0, `UTG_RESP_SLV);
        wchk(`UTG_STAT_OFFS, 32'h0, `UTG_RESP_SLV);
        wst = 4'he;
        wchk(`UTG_TPR_OFFS, 32'h0, `UTG_RESP_OKAY);
        wst = 4'hf;
        rchk(`UTG_TPR_OFFS, 32'h0000_0080, `UTG_RESP_OKAY);
        $display("test map done");
        report_and_stop;
    end
endmodule : uart_tx_gate_half_duplex_tb

/* File: testbench/utg_station.sv */
// far-side model: shifter that ends each character, receiver that stays busy
// assumes loads arrive as one-cycle pulses on the port clock
`timescale 1ns/1ps
module utg_station (
    input  wire logic       clk_i,       // port clock
    input  wire logic       arst_n_i,    // async reset, low
    input  wire logic       load_i,      // shifter load pulse
    input  wire logic [7:0] dly_i,       // character time in cycles, >= 1
    input  wire logic       rx_go_i,     // start a reception
    input  wire logic [7:0] rx_len_i,    // reception time in cycles
    output logic            done_o,      // character fully sent
    output logic            rx_active_o  // reception running
);
    logic [7:0] tc; // cycles left of the character on the line
    logic [7:0] rc; // cycles left of the incoming character

    // done comes at least one cycle after the load, never with it
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tc     <= 8'h00;
            rc     <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= (tc == 8'h01);
            if (load_i) tc <= dly_i;
            else if (tc != 8'h00) tc <= tc - 8'h01;
            // the bench starts a reception only while transmit is quiet
            if (rx_go_i) rc <= rx_len_i;
            else if (rc != 8'h00) rc <= rc - 8'h01;
        end
    end

    assign rx_active_o = (rc != 8'h00); // receiver busy
endmodule : utg_station
